// file: hw/eoc_external_oscillator_control.sv
// Behaviour
// - Crystal mode enabled claims port1 bit0 and bit1 as crystal pins.
// - Capacitor, RC or CMOS mode claims only port1 bit1.
// - External clock divided by eight offered to timers and counter array.
// - Divided clock resynchronised to system clock, jitter within one system cycle.
// - External clock measurable against real-time clock via timer capture.
`timescale 1ns/1ps

module eoc_external_oscillator_control #(
    parameter int SETTLE_CYCLES = eoc_pkg::SETTLE_CYC
) (
    // Clock and reset.
    input  wire logic                 core_clk_i,
    input  wire logic                 nrst_i,
    // Register write port and readback.
    input  wire logic                 ctrl_we_i,
    input  wire logic [7:0]           ctrl_wdata_i,
    output logic [7:0]                ext_osc_control_reg_o,
    // Oscillator status and clock.
    input  wire logic                 ext_clk_i,
    input  wire logic                 amp_ok_i,
    output logic                      crystal_valid_flag_o,
    // Pin claims and stored configuration.
    output eoc_pkg::eoc_pins_t        pins_o,
    output eoc_pkg::eoc_cfg_t         cfg_o,
    // Peripheral clocks.
    output logic                      ext_div8_o,
    output logic                      ext_div8_tick_o,
    output logic                      rtc_capture_clk_o
);

    eoc_pkg::eoc_cfg_t cfg_r;
    logic              valid_r;
    logic [1:0]        ext_sync_r;
    logic              ext_prev_r;
    logic [2:0]        edge_cnt_r;
    logic              div_r;
    logic              div_prev_r;
    logic [24:0]       settle_r;
    logic              is_xtal;
    logic              enabled;
    logic              ext_rise;
    logic              settled;

    // Write data is stored minus the read-only flag and reserved bit.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_r <= eoc_pkg::CTRL_RESET[6:0] == 7'h00 ? '0 : '0;
        end else if (ctrl_we_i) begin
            cfg_r.mode              <= ctrl_wdata_i[eoc_pkg::MODE_LSB +: 3];
            cfg_r.freq_range_select <= ctrl_wdata_i[eoc_pkg::FREQ_LSB +: 3];
        end
    end

    assign is_xtal = cfg_r.mode[2:1] == eoc_pkg::MODE_XTAL[2:1];
    assign enabled = cfg_r.mode != eoc_pkg::MODE_OFF;
    assign cfg_o   = cfg_r;

    assign pins_o.bit0_claim = is_xtal;
    assign pins_o.bit1_claim = enabled;

    // The settle counter holds off the flag until amplitude is stable.
    assign settled = settle_r >= 25'(SETTLE_CYCLES);

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            settle_r <= '0;
            valid_r  <= 1'b0;
        end else if (!is_xtal) begin
            settle_r <= '0;
            valid_r  <= 1'b0;
        end else begin
            if (!settled) begin
                settle_r <= settle_r + 25'h0000001;
            end
            valid_r <= settled && amp_ok_i;
        end
    end

    assign crystal_valid_flag_o = valid_r;
    assign ext_osc_control_reg_o = {valid_r, cfg_r.mode, 1'b0,
                                    cfg_r.freq_range_select};

    // The external clock is sampled twice, then its rises are counted.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_sync_r <= '0;
            ext_prev_r <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[0], ext_clk_i};
            ext_prev_r <= ext_sync_r[1];
        end
    end

    assign ext_rise = ext_sync_r[1] && !ext_prev_r && enabled;

    // Toggle every fourth rise gives a divide by eight.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            edge_cnt_r <= '0;
            div_r      <= 1'b0;
            div_prev_r <= 1'b0;
        end else begin
            div_prev_r <= div_r;
            if (!enabled) begin
                edge_cnt_r <= '0;
                div_r      <= 1'b0;
            end else if (ext_rise) begin
                if (edge_cnt_r == eoc_pkg::DIV_LAST) begin
                    edge_cnt_r <= '0;
                    div_r      <= ~div_r;
                end else begin
                    edge_cnt_r <= edge_cnt_r + 3'h1;
                end
            end
        end
    end

    assign ext_div8_o        = div_r;
    assign ext_div8_tick_o   = div_r && !div_prev_r;
    assign rtc_capture_clk_o = div_r;

endmodule : eoc_external_oscillator_control

// file: hw/eoc_pkg.sv
package eoc_pkg;

    // Oscillator mode field values of the control register.
    localparam logic [2:0] MODE_OFF      = 3'h0;
    localparam logic [2:0] MODE_CMOS     = 3'h2;
    localparam logic [2:0] MODE_CMOS_DIV = 3'h3;
    localparam logic [2:0] MODE_RC       = 3'h4;
    localparam logic [2:0] MODE_CAP      = 3'h5;
    localparam logic [2:0] MODE_XTAL     = 3'h6;
    localparam logic [2:0] MODE_XTAL_DIV = 3'h7;

    // Control register layout and reset value.
    localparam int         VALID_BIT     = 7;
    localparam int         MODE_LSB      = 4;
    localparam int         FREQ_LSB      = 0;
    localparam logic [7:0] CTRL_RESET    = 8'h00;

    // Peripheral clock divide ratio.
    localparam int         EXT_DIV       = 8;
    localparam logic [2:0] DIV_LAST      = 3'(EXT_DIV / 2 - 1);

    // Least settle time before the valid flag may rise, in system cycles.
    localparam int         CLK_MHZ       = 25;
    localparam int         SETTLE_US     = 1000;
    localparam int         SETTLE_CYC    = SETTLE_US * CLK_MHZ;

    typedef struct packed {
        logic bit0_claim;
        logic bit1_claim;
    } eoc_pins_t;

    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] freq_range_select;
    } eoc_cfg_t;

endpackage : eoc_pkg

// file: dv/eoc_properties.sv
`timescale 1ns/1ps
module eoc_properties (
    input wire logic               core_clk_i,
    input wire logic               nrst_i,
    input wire logic [7:0]         ext_osc_control_reg_o,
    input wire logic               amp_ok_i,
    input wire logic               crystal_valid_flag_o,
    input wire eoc_pkg::eoc_pins_t pins_o,
    input wire logic               ext_div8_o,
    input wire logic               ext_div8_tick_o,
    input wire logic               rtc_capture_clk_o
);
    wire logic [2:0] md = ext_osc_control_reg_o[6:4];
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    xtal_pins_a: assert property (md[2:1] == 2'h3 |-> pins_o == 2'h3)
        else $error("crystal mode pins wrong");
    one_pin_a: assert property (md inside {[3'h1:3'h5]} |-> pins_o == 2'h1)
        else $error("single pin mode pins wrong");
    pins_free_a: assert property (md == 3'h0 |-> pins_o == 2'h0)
        else $error("pins held while off");
    valid_gate_a: assert property (crystal_valid_flag_o |->
        $past(md[2:1]) == 2'h3 && $past(amp_ok_i))
        else $error("valid without stable crystal");
    valid_mirror_a: assert property (
        ext_osc_control_reg_o[7] == crystal_valid_flag_o)
        else $error("readback valid mismatch");
    tick_rise_a: assert property ($rose(ext_div8_o) |-> ##[0:1] ext_div8_tick_o)
        else $error("no tick on divided rise");
    div_hold_a: assert property ($rose(ext_div8_o) |=> ext_div8_o[*8])
        else $error("divided clock high too short");
    capture_clk_a: assert property (rtc_capture_clk_o == ext_div8_o)
        else $error("capture clock differs");
endmodule : eoc_properties
bind eoc_external_oscillator_control eoc_properties eoc_properties_i (
    .core_clk_i, .nrst_i, .ext_osc_control_reg_o, .amp_ok_i,
    .crystal_valid_flag_o, .pins_o, .ext_div8_o, .ext_div8_tick_o,
    .rtc_capture_clk_o);

// file: dv/eoc_osc_model.sv
`timescale 1ns/1ps
module eoc_osc_model (
    input  wire logic en_i,
    output logic      ext_clk_o,
    output logic      amp_ok_o
);
    int n = 0;
    // Oscillates at a quarter of the system rate only while enabled.
    // Its pins are taken as skipped analog inputs with latches high.
    initial begin
        ext_clk_o = 1'h0;
        amp_ok_o = 1'h0;
        forever begin
            #80;
            ext_clk_o = en_i & ~ext_clk_o;
            n = en_i ? n + 1 : 0;
            amp_ok_o = n > 4;
        end
    end
endmodule : eoc_osc_model

// file: dv/eoc_external_oscillator_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin \
    err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module eoc_external_oscillator_control_tb_top;
    logic               core_clk_i = 1'h0;
    logic               nrst_i = 1'h0;
    logic               ctrl_we_i = 1'h0;
    logic               we_seen = 1'h0;
    logic [7:0]         ctrl_wdata_i = 8'h00;
    logic [7:0]         rd;
    logic               vld, ext_clk_i, amp_ok_i, div, tick, cap;
    logic [8:0]         ex;
    logic [8:0]         q[$];
    eoc_pkg::eoc_pins_t pins;
    eoc_pkg::eoc_cfg_t  cfg;
    int                 err_total = 0, n_compared = 0, seed = 76, c;
    eoc_external_oscillator_control #(.SETTLE_CYCLES(20))
        eoc_external_oscillator_control_i (.core_clk_i, .nrst_i,
        .ctrl_we_i, .ctrl_wdata_i, .ext_osc_control_reg_o(rd), .ext_clk_i,
        .amp_ok_i, .crystal_valid_flag_o(vld), .pins_o(pins), .cfg_o(cfg),
        .ext_div8_o(div), .ext_div8_tick_o(tick), .rtc_capture_clk_o(cap));
    eoc_osc_model eoc_osc_model_i (.en_i(cfg.mode != 3'h0),
        .ext_clk_o(ext_clk_i), .amp_ok_o(amp_ok_i));
    initial forever #20 core_clk_i = ~core_clk_i;
    task automatic end_of_test;
        if (err_total == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [7:0] d);
        @(negedge core_clk_i);
        ctrl_we_i <= 1'h1;
        ctrl_wdata_i <= d;
        q.push_back({(d[6:5] == 2'h3) ? 2'h3 : {1'h0, d[6:4] != 3'h0},
                     d[6:4], 1'h0, d[2:0]});
    endtask : wr
    always @(posedge core_clk_i) we_seen <= ctrl_we_i;
    always @(negedge core_clk_i) if (we_seen) begin
        ex = q.pop_front();
        `CHK("ctrl", ex, {pins, rd[6:0]})
    end
    initial begin
        logic [7:0] d;
        repeat (3) @(negedge core_clk_i);
        nrst_i = 1'h1;
        for (int m = 0; m < 8; m++) begin
            d = 8'($random(seed));
            wr({d[7], 3'(m), d[3:0]});
        end
        wr(8'h00);
        wr(8'h67);
        @(negedge core_clk_i) ctrl_we_i <= 1'h0;
        for (c = 1; c < 200 && !vld; c++) @(negedge core_clk_i);
        `CHK("settle", 1'h1, c > 20 && c < 24)
        c = 0;
        repeat (64) begin
            @(negedge core_clk_i);
            c += tick;
            `CHK("cap", div, cap)
        end
        `CHK("ticks", 2, c)
        wr(8'h50);
        @(negedge core_clk_i) ctrl_we_i <= 1'h0;
        @(negedge core_clk_i);
        `CHK("valid", 1'h0, vld)
        end_of_test();
    end
endmodule : eoc_external_oscillator_control_tb_top
